// ### rtl/tcd_pkg.sv
// Shared constants and types for the thermocouple channel setup decoder.
// Assumes a single 100 MHz clock and a synchronous backplane port.
package tcd_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_CH  = 8;
	localparam int WORD_W  = 16;
	localparam int CH_AW   = 3;

	// ==========================================================
	// Field positions of channel_setup_word
	localparam int POS_ENABLE   = 0;
	localparam int POS_TYPE_LO  = 1;
	localparam int POS_TYPE_HI  = 4;
	localparam int POS_FMT_LO   = 5;
	localparam int POS_FMT_HI   = 6;
	localparam int POS_OPEN_LO  = 7;
	localparam int POS_OPEN_HI  = 8;
	localparam int POS_UNITS    = 9;
	localparam int POS_FILT_LO  = 10;
	localparam int POS_FILT_HI  = 11;
	localparam int POS_RSV_LO   = 12;
	localparam int POS_RSV_HI   = 14;
	localparam int POS_IMAGE    = 15;

	// Bits 12 to 14 carry no setting and are dropped on write.
	localparam logic [WORD_W-1:0] SETUP_KEEP_MASK = 16'h8fff;
	localparam logic [WORD_W-1:0] SETUP_RESET     = 16'h0000;
	localparam logic [WORD_W-1:0] DATA_RESET      = 16'h0000;

	// ==========================================================
	// Status word error flag positions (bits 0 to 11 echo the setup)
	localparam int POS_ST_OPEN  = 12;
	localparam int POS_ST_UNDER = 13;
	localparam int POS_ST_OVER  = 14;
	localparam int POS_ST_ERR   = 15;

	// ==========================================================
	// Types
	typedef struct packed {
		logic       showStatus;
		logic [1:0] filterSel;
		logic       fahrenheit;
		logic [1:0] openMode;
		logic [1:0] dataFormat;
		logic [3:0] sensorType;
		logic       enable;
	} tcd_chan_cfg_t;

	typedef struct packed {
		logic openCircuit;
		logic underRange;
		logic overRange;
	} tcd_chan_err_t;

	typedef struct packed {
		logic              wr;
		logic [CH_AW-1:0]  ch;
		logic [WORD_W-1:0] data;
	} tcd_setup_wr_t;

	typedef enum logic [1:0] {
		ST_WAIT_CFG = 2'b01,
		ST_RUN      = 2'b10
	} tcd_state_t;

endpackage : tcd_pkg

// ### rtl/tcd_cfg_decode.sv
// Splits one stored channel_setup_word into its channel settings.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module tcd_cfg_decode
	import tcd_pkg::*;
(
	// Stored setup word
	input  wire logic [WORD_W-1:0] setupWord,
	// Decoded settings
	output tcd_chan_cfg_t          chanCfg
);

	always_comb begin
		chanCfg.enable     = setupWord[POS_ENABLE];
		chanCfg.sensorType = setupWord[POS_TYPE_HI:POS_TYPE_LO];
		chanCfg.dataFormat = setupWord[POS_FMT_HI:POS_FMT_LO];
		chanCfg.openMode   = setupWord[POS_OPEN_HI:POS_OPEN_LO];
		chanCfg.fahrenheit = setupWord[POS_UNITS];
		chanCfg.filterSel  = setupWord[POS_FILT_HI:POS_FILT_LO];
		chanCfg.showStatus = setupWord[POS_IMAGE];
	end

endmodule : tcd_cfg_decode

// ### rtl/tcd_status_word.sv
// Builds one channel's status word and its data-valid flag.
// Error inputs come from conversion logic on the same clock.
`timescale 1ns/10ps
module tcd_status_word
	import tcd_pkg::*;
(
	// Channel settings and errors
	input  tcd_chan_cfg_t          chanCfg,
	input  tcd_chan_err_t          chanErr,
	// Results
	output logic [WORD_W-1:0]      statusWord,
	output logic                   dataValid
);

	logic anyErr;

	always_comb begin
		anyErr     = chanErr.openCircuit | chanErr.underRange | chanErr.overRange;
		statusWord = {anyErr, chanErr.overRange, chanErr.underRange,
			chanErr.openCircuit, chanCfg.filterSel, chanCfg.fahrenheit,
			chanCfg.openMode, chanCfg.dataFormat, chanCfg.sensorType,
			chanCfg.enable};
		dataValid  = chanCfg.enable & ~anyErr;
	end

endmodule : tcd_status_word

// ### rtl/tcd_channel_config.sv
// Eight-channel setup word store, decoder and input image selector.
// Assumes the backplane port and the converters run on the same clock.
`timescale 1ns/10ps
module tcd_channel_config
	import tcd_pkg::*;
(
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	// Output image write from the host
	input  wire logic                          setupWr,
	input  wire logic [CH_AW-1:0]              setupCh,
	input  wire logic [WORD_W-1:0]             setupData,
	// Input image read from the host
	input  wire logic                          imageRd,
	input  wire logic [CH_AW-1:0]              imageCh,
	output logic      [WORD_W-1:0]             imageData,
	output logic                               imageAck,
	// Converter side
	input  wire logic [NUM_CH-1:0]             convStrobe,
	input  wire logic [NUM_CH-1:0][WORD_W-1:0] convValue,
	input  tcd_chan_err_t [NUM_CH-1:0]         convErr,
	// Decoded settings and state
	output tcd_chan_cfg_t [NUM_CH-1:0]         chanCfg,
	output logic      [NUM_CH-1:0]             chanValid,
	output logic                               setupComplete
);

	// ==========================================================
	// Signals
	tcd_setup_wr_t                   wrReq;
	logic [WORD_W-1:0]               setupMem_q [NUM_CH];
	logic [WORD_W-1:0]               setupMem_d [NUM_CH];
	logic [NUM_CH-1:0]               written_q;
	logic [NUM_CH-1:0]               written_d;
	tcd_state_t                      state_q;
	tcd_state_t                      state_d;
	tcd_chan_cfg_t [NUM_CH-1:0]      cfgNow;
	tcd_chan_cfg_t [NUM_CH-1:0]      chanCfg_d;
	logic [NUM_CH-1:0][WORD_W-1:0]   statusNow;
	logic [NUM_CH-1:0]               validNow;
	logic [NUM_CH-1:0][WORD_W-1:0]   dataWord_q;
	logic [NUM_CH-1:0][WORD_W-1:0]   dataWord_d;
	logic [WORD_W-1:0]               imageData_d;
	logic                            imageAck_d;
	logic [NUM_CH-1:0]               writeHit;
	logic [NUM_CH-1:0]               takeValue;
	logic [NUM_CH-1:0][WORD_W-1:0]   imageWord;
	logic [NUM_CH-1:0]               chanValid_d;
	logic                            setupComplete_d;

	// Reserved bits are cleared so they never reach decode.
	function automatic logic [WORD_W-1:0] keepSetup(input logic [WORD_W-1:0] w);
		keepSetup = w & SETUP_KEEP_MASK;
	endfunction : keepSetup

	// One decode of the write channel feeds both the store and the data
	// word clear, so the two can never disagree on which slot was hit.
	function automatic logic hitsChannel(input tcd_setup_wr_t req, input int idx);
		hitsChannel = req.wr && (req.ch == CH_AW'(idx));
	endfunction : hitsChannel

	// The slot shows the status word when asked for; otherwise the held value,
	// forced to zero while the host may not trust it.
	function automatic logic [WORD_W-1:0] pickImage(
		input tcd_chan_cfg_t     cfg,
		input logic [WORD_W-1:0] status,
		input logic              valid,
		input logic [WORD_W-1:0] data
	);
		if (cfg.showStatus) begin
			pickImage = status;
		end else if (valid) begin
			pickImage = data;
		end else begin
			pickImage = DATA_RESET;
		end
	endfunction : pickImage

	// Zeroes every field of a disabled channel's settings.
	function automatic tcd_chan_cfg_t gateCfg(input tcd_chan_cfg_t cfg);
		gateCfg = cfg;
		if (!cfg.enable) begin
			gateCfg = '0;
		end
	endfunction : gateCfg

	assign wrReq = '{wr: setupWr, ch: setupCh, data: setupData};

	// ==========================================================
	// Write decode
	// No write is ever refused; a repeat to the same channel simply
	// replaces the stored word.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			writeHit[i] = hitsChannel(wrReq, i);
		end
	end

	// ==========================================================
	// Setup word store
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			setupMem_d[i] = setupMem_q[i];
			written_d[i]  = written_q[i];
			if (writeHit[i]) begin
				setupMem_d[i] = keepSetup(wrReq.data);
				written_d[i]  = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				setupMem_q[i] <= SETUP_RESET;
			end
			written_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				setupMem_q[i] <= setupMem_d[i];
			end
			written_q <= written_d;
		end
	end

	// ==========================================================
	// Startup tracking
	// The host loads every word on its first scan; until its word arrives,
	// a channel runs on the all-zero setup, which leaves it disabled.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_WAIT_CFG: begin
				if (&written_d) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_WAIT_CFG;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_WAIT_CFG;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Per-channel decode and status
	for (genvar c = 0; c < NUM_CH; c++) begin : gChan
		tcd_cfg_decode uDecode (
			.setupWord (setupMem_q[c]),
			.chanCfg   (cfgNow[c])
		);
		tcd_status_word uStatus (
			.chanCfg    (cfgNow[c]),
			.chanErr    (convErr[c]),
			.statusWord (statusNow[c]),
			.dataValid  (validNow[c])
		);
	end

	// Settings go out only for enabled channels so that a disabled
	// channel never steers its converter.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			chanCfg_d[i] = gateCfg(cfgNow[i]);
		end
	end

	// ==========================================================
	// Converter capture
	// A strobe from a disabled channel is dropped here, so a converter
	// left running after its channel is switched off changes nothing.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			takeValue[i] = convStrobe[i] & cfgNow[i].enable;
		end
	end

	// ==========================================================
	// Data words
	// A fresh setup write clears the channel's held value, so stale data
	// measured under the old sensor type or format is never shown.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			dataWord_d[i] = dataWord_q[i];
			if (writeHit[i]) begin
				dataWord_d[i] = DATA_RESET;
			end else if (takeValue[i]) begin
				dataWord_d[i] = convValue[i];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dataWord_q <= '0;
		end else begin
			dataWord_q <= dataWord_d;
		end
	end

	// ==========================================================
	// Input image
	// Every slot's word is formed all the time and the read only picks one.
	// This costs a wide mux but keeps the read path free of per-read logic.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			imageWord[i] = pickImage(cfgNow[i], statusNow[i], validNow[i], dataWord_q[i]);
		end
	end

	// The word captured on a read stands until the next read.
	always_comb begin
		imageAck_d  = imageRd;
		imageData_d = imageData;
		if (imageRd) begin
			imageData_d = imageWord[imageCh];
		end
	end

	// ==========================================================
	// Image port registers
	// The ack is a fixed one-cycle echo of the read strobe; there is no
	// wait state, so the host may read back to back.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			imageData <= DATA_RESET;
			imageAck  <= 1'b0;
		end else begin
			imageData <= imageData_d;
			imageAck  <= imageAck_d;
		end
	end

	// ==========================================================
	// Settings registers
	// Registered so that the converters see a whole setup word change
	// on one edge, never a mix of old and new fields.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chanCfg <= '0;
		end else begin
			chanCfg <= chanCfg_d;
		end
	end

	// ==========================================================
	// Data valid flags
	// The flags follow the live error inputs one cycle late, so a host
	// that samples flag and slot together sees a matching pair.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			chanValid_d[i] = validNow[i];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chanValid <= '0;
		end else begin
			chanValid <= chanValid_d;
		end
	end

	// ==========================================================
	// Startup flag
	// Taken from the next state so that it rises on the edge that stores
	// the last missing word, not one cycle after it.
	always_comb begin
		setupComplete_d = 1'b0;
		case (state_d)
			ST_RUN: begin
				setupComplete_d = 1'b1;
			end
			default: begin
				setupComplete_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			setupComplete <= 1'b0;
		end else begin
			setupComplete <= setupComplete_d;
		end
	end

endmodule : tcd_channel_config

// ### verif/tcd_channel_config_monitor.sv
// Checker for the setup decode and image slot of tcd_channel_config.
// Sees only top ports; the bind stands at the foot of this file.
`timescale 1ns/10ps
module tcd_channel_config_monitor
	import tcd_pkg::*;
(
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  rst_n,
	// Host port
	input wire logic                  setupWr,
	input wire logic [CH_AW-1:0]      setupCh,
	input wire logic [WORD_W-1:0]     setupData,
	input wire logic                  imageRd,
	input wire logic [CH_AW-1:0]      imageCh,
	input wire logic [WORD_W-1:0]     imageData,
	// Converter errors and settings
	input tcd_chan_err_t [NUM_CH-1:0] convErr,
	input tcd_chan_cfg_t [NUM_CH-1:0] chanCfg
);
	tcd_setup_wr_t     w1_q, w2_q;
	tcd_chan_cfg_t     cw;
	logic [WORD_W-1:0] shadow_q [NUM_CH];
	logic [WORD_W-1:0] sr;
	tcd_chan_err_t     er;
	logic [WORD_W-1:0] dw;
	logic              wrOn;
	// A two-deep copy of the write lets the checks find the slot written.
	always_ff @(posedge clock) begin
		w1_q <= {setupWr, setupCh, setupData};
		w2_q <= w1_q;
	end
	// A disabled slot shows nothing of its word on the settings port, so the
	// checker keeps its own copy of every setup word.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				shadow_q[i] <= '0;
			end
		end else if (setupWr) begin
			shadow_q[setupCh] <= setupData;
		end
	end
	assign cw = chanCfg[w2_q.ch];
	assign dw = w2_q.data;
	assign sr = shadow_q[imageCh];
	assign er = convErr[imageCh];
	assign wrOn = setupWr & setupData[0];
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ========
	// Settings and image slot
	property p_off; setupWr && !setupData[0] |-> ##2 cw == '0; endproperty
	a_off: assert property (p_off) else $error("disabled slot kept settings");
	property p_type; wrOn |-> ##2 cw.sensorType == dw[4:1]; endproperty
	a_type: assert property (p_type) else $error("sensor type wrong");
	property p_units; wrOn |-> ##2 cw.fahrenheit == dw[9]; endproperty
	a_units: assert property (p_units) else $error("units wrong");
	property p_filter; wrOn |-> ##2 cw.filterSel == dw[11:10]; endproperty
	a_filter: assert property (p_filter) else $error("filter wrong");
	property p_open; wrOn |-> ##2 cw.openMode == dw[8:7]; endproperty
	a_open: assert property (p_open) else $error("open circuit mode wrong");
	property p_format; wrOn |-> ##2 cw.dataFormat == dw[6:5]; endproperty
	a_format: assert property (p_format) else $error("format wrong");
	property p_word; wrOn |-> ##2 cw == {dw[15], dw[11:0]}; endproperty
	a_word: assert property (p_word) else $error("settings wrong");
	property p_zero;
		imageRd && !sr[15] && (!sr[0] || er != '0) |=> imageData == '0;
	endproperty
	a_zero: assert property (p_zero) else $error("invalid data shown");
	property p_status;
		imageRd && sr[15] |=> imageData == $past({|er, er[0], er[1], er[2], sr[11:0]});
	endproperty
	a_status: assert property (p_status) else $error("status word wrong");
endmodule : tcd_channel_config_monitor
bind tcd_channel_config tcd_channel_config_monitor u_monitor (
	.clock(clock), .rst_n(rst_n), .setupWr(setupWr), .setupCh(setupCh),
	.setupData(setupData), .imageRd(imageRd), .imageCh(imageCh),
	.imageData(imageData), .convErr(convErr), .chanCfg(chanCfg));

// ### verif/tcd_host_model.sv
// Host model: writes setup words and reads input image slots.
// The bench calls its tasks; lines move just after falling edges.
`timescale 1ns/10ps
module tcd_host_model
	import tcd_pkg::*;
(
	// Clock
	input wire logic              clock,
	// Image port
	output logic                  setupWr,
	output logic [CH_AW-1:0]      setupCh,
	output logic [WORD_W-1:0]     setupData,
	output logic                  imageRd,
	output logic [CH_AW-1:0]      imageCh,
	input wire logic [WORD_W-1:0] imageData,
	input wire logic              imageAck
);
	int gap = 0;
	initial begin
		setupWr = 1'b0;
		imageRd = 1'b0;
		setupCh = '0;
		imageCh = '0;
		setupData = '0;
	end
	// Idle lines flip to the inverse, so a capture without strobe shows up.
	task automatic wr(input int c, input int w);
		repeat (gap) @(negedge clock);
		@(negedge clock);
		setupWr = 1'b1;
		setupCh = c[CH_AW-1:0];
		setupData = w[WORD_W-1:0];
		@(negedge clock);
		setupWr = 1'b0;
		setupCh = ~setupCh;
		setupData = ~setupData;
	endtask : wr
	task automatic rd(input int c, output logic a, output logic [WORD_W-1:0] d);
		repeat (gap) @(negedge clock);
		@(negedge clock);
		imageRd = 1'b1;
		imageCh = c[CH_AW-1:0];
		@(negedge clock);
		imageRd = 1'b0;
		imageCh = ~imageCh;
		a = imageAck;
		d = imageData;
	endtask : rd
endmodule : tcd_host_model

// ### verif/test_tcd_channel_config.sv
// Bench for tcd_channel_config with a reference model of the slots.
// The host model drives the image port; converter inputs move here.
`timescale 1ns/10ps
module test_tcd_channel_config
	import tcd_pkg::*;
;
	logic                          clock, rst_n, setupWr, imageRd, imageAck, done, ack;
	logic [CH_AW-1:0]              setupCh, imageCh;
	logic [WORD_W-1:0]             setupData, imageData, got, ec;
	logic [NUM_CH-1:0]             convStrobe, chanValid;
	logic [NUM_CH-1:0][WORD_W-1:0] convValue;
	tcd_chan_err_t [NUM_CH-1:0]    convErr;
	tcd_chan_cfg_t [NUM_CH-1:0]    chanCfg;
	int                            failures, checked, seed, setup[NUM_CH], dat[NUM_CH];
	tcd_channel_config dut (.clock(clock), .rst_n(rst_n), .setupWr(setupWr),
		.setupCh(setupCh), .setupData(setupData), .imageRd(imageRd), .imageCh(imageCh),
		.imageData(imageData), .imageAck(imageAck), .convStrobe(convStrobe),
		.convValue(convValue), .convErr(convErr), .chanCfg(chanCfg),
		.chanValid(chanValid), .setupComplete(done));
	tcd_host_model host (.clock(clock), .setupWr(setupWr), .setupCh(setupCh),
		.setupData(setupData), .imageRd(imageRd), .imageCh(imageCh),
		.imageData(imageData), .imageAck(imageAck));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic final_report();
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	// Reference slot: status word, data word, or zero when the data is unusable.
	function automatic logic [WORD_W-1:0] slot(input int c);
		logic [2:0] e;
		e = convErr[c];
		if (setup[c][15]) return {|e, e[0], e[1], e[2], setup[c][11:0]};
		if (!setup[c][0]) return '0;
		return (e == 3'h0) ? dat[c][15:0] : '0;
	endfunction : slot
	initial begin
		seed = 32'h9fafe75d;
		failures = 0;
		checked = 0;
		rst_n = 1'b0;
		convStrobe = '0;
		convValue = '0;
		convErr = '0;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		chk("complete", 16'h0, {15'h0, done});
		for (int r = 0; r < NUM_CH; r++) begin
			host.gap = r % 2;
			foreach (setup[c]) begin
				setup[c] = $random(seed);
				dat[c] = 0;
				host.wr(c, setup[c]);
			end
			repeat (2) @(negedge clock);
			chk("complete", 16'h1, {15'h0, done});
			foreach (setup[c]) begin
				ec = setup[c][0] ? {3'h0, setup[c][15], setup[c][11:0]} : 16'h0;
				chk("cfg", ec, {3'h0, chanCfg[c]});
				chk("cfgHi", ec[15:5], {3'h0, chanCfg[c][12:5]});
			end
			convErr = 24'($random(seed) & $random(seed));
			foreach (setup[c]) begin
				convValue[c] = 16'($random(seed));
				if (setup[c][0]) dat[c] = convValue[c];
			end
			convStrobe = '1;
			@(negedge clock);
			convStrobe = '0;
			// Rewriting one slot must drop the value it held.
			host.wr(r, setup[r]);
			dat[r] = 0;
			repeat (2) @(negedge clock);
			foreach (setup[c]) begin
				ec = {15'h0, setup[c][0] && convErr[c] == 3'h0};
				chk("valid", ec, {15'h0, chanValid[c]});
				host.rd(c, ack, got);
				chk("ack", 16'h1, {15'h0, ack});
				chk("image", slot(c), got);
			end
		end
		// A reset in mid-run must clear the settings of channels 0 and 7, the valid flags and the startup flag.
		@(negedge clock);
		rst_n = 1'b0;
		@(negedge clock);
		chk("reset cfg", 16'h0, {3'h0, chanCfg[0] | chanCfg[7]});
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		chk("reset complete", 16'h0, {15'h0, done});
		chk("reset valid", 16'h0, {8'h0, chanValid});
		final_report();
	end
endmodule : test_tcd_channel_config
